// ### ref_clock_defines.svh
// Constants for the reference clock source control block.
`ifndef REF_CLOCK_DEFINES_SVH
`define REF_CLOCK_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_W            8
`define OFS_CLOCK_CONN    8'h00
`define OFS_EXPERT_CFG    8'h04
`define OFS_STATUS        8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_OSC_DISABLE   0
`define BIT_EXT_SELECT    1
`define BIT_AMP_OVERRIDE  2
`define BIT_OBSERVE_SEL   3
`define FLD_DELAY_LO      0
`define FLD_DELAY_HI      1
`define ST_AMP_OK         0
`define ST_REFCLK_VALID   1
`define ST_OSC_RUN        2
`define ST_EXT_RUN        3
`define ST_DELAY_DONE     4
`define ST_STATE_LO       8
`define ST_STATE_HI       9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CLOCK_CONN    4'h0
`define RST_DELAY_SEL     2'h1

// ----------------------------------------------------------------------
// Start-up delay terminal counts in raw clock pulses
// ----------------------------------------------------------------------
`define DLY_W             12
`define DLY_TERM0         12'h010
`define DLY_TERM1         12'h040
`define DLY_TERM2         12'h100
`define DLY_TERM3         12'h400

// ----------------------------------------------------------------------
// Pulse shape qualification, in I_CLK samples
// ----------------------------------------------------------------------
`define PH_W              3
`define MIN_PHASE         3'h2
`define MISS_W            4
`define MISS_CYCLES       4'h8

`endif

// ### ref_clock_pkg.sv
// Types shared by the reference clock source control block.
package ref_clock_pkg;

   typedef enum logic [1:0] {
      SRC_OFF  = 2'h0,
      SRC_XO   = 2'h1,
      SRC_STOP = 2'h3,
      SRC_EXT  = 2'h2
   } src_state_t;

   typedef struct packed {
      logic observe_sel;
      logic amplitude_ok_override;
      logic ext_buffer_select;
      logic osc_disable_bit;
   } clock_conn_t;

   typedef struct packed {
      logic paddr_ok;
      logic [7:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

// ### raw_pulse_qualifier.sv
// Samples the merged raw clock and qualifies its pulses by width.
`timescale 1ns/1ns
`include "ref_clock_defines.svh"

module raw_pulse_qualifier (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_raw,
   output logic      o_raw_q,
   output logic      o_rise,
   output logic      o_good_rise,
   output logic      o_missing
);
   logic                 raw_q_ff;
   logic                 prev_ff;
   logic                 hi_ok_ff;
   logic [`PH_W-1:0]     hi_cnt_ff;
   logic [`PH_W-1:0]     lo_cnt_ff;
   logic [`MISS_W-1:0]   idle_ff;

   assign o_raw_q     = raw_q_ff;
   assign o_rise      = raw_q_ff & ~prev_ff;
   // Thin pulses near either duty extreme produce no qualified edge.
   assign o_good_rise = o_rise & hi_ok_ff & (lo_cnt_ff >= `MIN_PHASE);
   assign o_missing   = (idle_ff >= `MISS_CYCLES);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         raw_q_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         raw_q_ff <= i_raw;
         prev_ff  <= raw_q_ff;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         hi_cnt_ff <= '0;
         lo_cnt_ff <= '0;
         hi_ok_ff  <= 1'b0;
      end else if (raw_q_ff) begin
         lo_cnt_ff <= prev_ff ? lo_cnt_ff : '0;
         hi_cnt_ff <= !prev_ff ? `PH_W'(1) : (hi_cnt_ff == '1 ? hi_cnt_ff : hi_cnt_ff + `PH_W'(1));
      end else begin
         if (prev_ff) begin
            hi_ok_ff <= (hi_cnt_ff >= `MIN_PHASE);
         end
         lo_cnt_ff <= prev_ff ? `PH_W'(1) : (lo_cnt_ff == '1 ? lo_cnt_ff : lo_cnt_ff + `PH_W'(1));
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset || o_rise) begin
         idle_ff <= '0;
      end else if (!o_missing) begin
         idle_ff <= idle_ff + `MISS_W'(1);
      end
   end
endmodule

// ### startup_delay_counter.sv
// Counts qualified raw clock pulses up to a selected terminal count.
`timescale 1ns/1ns
`include "ref_clock_defines.svh"

module startup_delay_counter (
   input  wire logic            i_clk,
   input  wire logic            i_reset,
   input  wire logic            i_hold,
   input  wire logic            i_pulse,
   input  wire logic [1:0]      i_sel,
   output logic                 o_done
);
   logic [`DLY_W-1:0] cnt_ff;
   logic [`DLY_W-1:0] term;

   always_comb begin
      unique case (i_sel)
         2'h0: term = `DLY_TERM0;
         2'h1: term = `DLY_TERM1;
         2'h2: term = `DLY_TERM2;
         2'h3: term = `DLY_TERM3;
      endcase
   end

   assign o_done = (cnt_ff >= term);

   always_ff @(posedge i_clk) begin
      if (i_reset || i_hold) begin
         cnt_ff <= '0;
      end else if (i_pulse && !o_done) begin
         cnt_ff <= cnt_ff + `DLY_W'(1);
      end
   end

   done_holds_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_done && !i_hold && $stable(i_sel) |=> $stable(cnt_ff))
      else $error("Delay counter advanced after end of delay.");
endmodule

// ### ref_clock_control.sv
// Reference clock source selection, start-up delay and clock gate with APB registers.
`timescale 1ns/1ns
`include "ref_clock_defines.svh"

module ref_clock_control
   import ref_clock_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RESET,
   input  wire logic        I_PD,
   input  wire logic        I_OSC_RAW,
   input  wire logic        I_EXT_CLK,
   input  wire logic        I_AMPLITUDE_OK,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   output logic             O_OSC_RUN,
   output logic             O_EXT_BUF_RUN,
   output logic             O_REFCLK,
   output logic             O_REFCLK_VALID,
   output logic             O_OBSERVE,
   output logic             O_PT_RECAL
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   src_state_t   state_ff;
   src_state_t   nxt_state;
   clock_conn_t  ctrl_ff;
   apb_req_t     req;
   logic [1:0]   delay_sel_ff;
   logic         osc_run_ff;
   logic         ext_run_ff;
   logic         valid_ff;
   logic         nxt_valid;
   logic         gate_ff;
   logic         refclk_ff;
   logic         observe_ff;
   logic         recal_ff;
   logic [31:0]  prdata_ff;
   logic         pready_ff;
   logic         pslverr_ff;
   logic [31:0]  rd_mux;
   logic         xo_req;
   logic         ext_req;
   logic         raw_clk;
   logic         raw_q;
   logic         raw_rise;
   logic         good_rise;
   logic         missing;
   logic         delay_done;
   logic         delay_hold;
   logic         bypass;
   logic         end_of_delay;
   logic         amp_lost;

   assign O_PRDATA       = prdata_ff;
   assign O_PREADY       = pready_ff;
   assign O_PSLVERR      = pslverr_ff;
   assign O_OSC_RUN      = osc_run_ff;
   assign O_EXT_BUF_RUN  = ext_run_ff;
   assign O_REFCLK       = refclk_ff;
   assign O_REFCLK_VALID = valid_ff;
   assign O_OBSERVE      = observe_ff;
   assign O_PT_RECAL     = recal_ff;

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   // The answer is prepared in the setup cycle so that the access phase
   // always lasts exactly one cycle.
   assign req.paddr    = I_PADDR;
   assign req.pwrite   = I_PWRITE;
   assign req.pwdata   = I_PWDATA;
   assign req.paddr_ok = (I_PADDR == `OFS_CLOCK_CONN) || (I_PADDR == `OFS_EXPERT_CFG) ||
                         (I_PADDR == `OFS_STATUS);

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (req.paddr)
         `OFS_CLOCK_CONN: rd_mux[3:0] = ctrl_ff;
         `OFS_EXPERT_CFG: rd_mux[`FLD_DELAY_HI:`FLD_DELAY_LO] = delay_sel_ff;
         `OFS_STATUS: begin
            rd_mux[`ST_AMP_OK]       = I_AMPLITUDE_OK;
            rd_mux[`ST_REFCLK_VALID] = valid_ff;
            rd_mux[`ST_OSC_RUN]      = osc_run_ff;
            rd_mux[`ST_EXT_RUN]      = ext_run_ff;
            rd_mux[`ST_DELAY_DONE]   = end_of_delay;
            rd_mux[`ST_STATE_HI:`ST_STATE_LO] = state_ff;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= I_PSEL && !I_PENABLE;
         pslverr_ff <= I_PSEL && !I_PENABLE && !req.paddr_ok;
         if (I_PSEL && !I_PENABLE && !req.pwrite) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         ctrl_ff      <= `RST_CLOCK_CONN;
         delay_sel_ff <= `RST_DELAY_SEL;
      end else if (I_PSEL && I_PENABLE && pready_ff && req.pwrite) begin
         if (req.paddr == `OFS_CLOCK_CONN) begin
            ctrl_ff <= req.pwdata[3:0];
         end
         if (req.paddr == `OFS_EXPERT_CFG) begin
            delay_sel_ff <= req.pwdata[`FLD_DELAY_HI:`FLD_DELAY_LO];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Source enable and transition control
   // ----------------------------------------------------------------------
   assign xo_req  = !I_PD && !ctrl_ff.osc_disable_bit;
   assign ext_req = !I_PD && ctrl_ff.osc_disable_bit && ctrl_ff.ext_buffer_select;

   // A source is only switched off once the gate is shut and ready is low,
   // so the gated clock never sees a truncated pulse. Power-down skips this.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SRC_OFF: begin
            if (xo_req) begin
               nxt_state = SRC_XO;
            end else if (ext_req) begin
               nxt_state = SRC_EXT;
            end
         end
         SRC_XO: begin
            if (I_PD) begin
               nxt_state = SRC_OFF;
            end else if (!xo_req) begin
               nxt_state = SRC_STOP;
            end
         end
         SRC_EXT: begin
            if (I_PD) begin
               nxt_state = SRC_OFF;
            end else if (!ext_req) begin
               nxt_state = SRC_STOP;
            end
         end
         SRC_STOP: begin
            if (I_PD || (!gate_ff && !valid_ff)) begin
               nxt_state = SRC_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         state_ff <= SRC_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         osc_run_ff <= 1'b0;
         ext_run_ff <= 1'b0;
      end else if (nxt_state != SRC_STOP) begin
         osc_run_ff <= (nxt_state == SRC_XO);
         ext_run_ff <= (nxt_state == SRC_EXT);
      end
   end

   // ----------------------------------------------------------------------
   // Raw clock merge and start-up delay
   // ----------------------------------------------------------------------
   assign raw_clk = (osc_run_ff & I_OSC_RAW) | (ext_run_ff & I_EXT_CLK);

   raw_pulse_qualifier u_qual (
      .i_clk       (I_CLK),
      .i_reset     (I_RESET),
      .i_raw       (raw_clk),
      .o_raw_q     (raw_q),
      .o_rise      (raw_rise),
      .o_good_rise (good_rise),
      .o_missing   (missing)
   );

   assign bypass     = ext_run_ff && !ctrl_ff.amplitude_ok_override;
   assign delay_hold = I_PD || (!I_AMPLITUDE_OK && !ctrl_ff.amplitude_ok_override) ||
                       (!osc_run_ff && !ext_run_ff);
   // Amplitude good releases the counter and, while the crystal runs, also gates ready via amp_lost.
   assign end_of_delay = bypass || delay_done;
   assign amp_lost     = osc_run_ff && !I_AMPLITUDE_OK && !ctrl_ff.amplitude_ok_override;

   startup_delay_counter u_delay (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_hold  (delay_hold && !bypass),
      .i_pulse (good_rise),
      .i_sel   (delay_sel_ff),
      .o_done  (delay_done)
   );

   // ----------------------------------------------------------------------
   // Reference ready, clock gate and outputs
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_valid = valid_ff;
      if (I_PD || missing || amp_lost || state_ff == SRC_STOP || state_ff == SRC_OFF) begin
         nxt_valid = 1'b0;
      end else if (raw_rise && end_of_delay) begin
         nxt_valid = 1'b1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         valid_ff <= 1'b0;
         recal_ff <= 1'b0;
      end else begin
         valid_ff <= nxt_valid;
         recal_ff <= nxt_valid && !valid_ff;
      end
   end

   // The enable moves only in the low phase, like a latch-based gate, so an
   // open or close never cuts a pulse. A stalled clock or power-down closes it directly.
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         gate_ff <= 1'b0;
      end else if (missing || I_PD) begin
         gate_ff <= 1'b0;
      end else if (!raw_q) begin
         gate_ff <= valid_ff;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         refclk_ff  <= 1'b0;
         observe_ff <= 1'b0;
      end else begin
         refclk_ff  <= raw_q && gate_ff;
         observe_ff <= ctrl_ff.observe_sel ? valid_ff : I_AMPLITUDE_OK;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   osc_run_a: assert property ($rose(osc_run_ff) |-> $past(xo_req))
      else $error("Oscillator started without a valid request.");

   ext_enable_a: assert property ($rose(ext_run_ff) |-> $past(ext_req && !xo_req))
      else $error("External buffer started without a valid request.");

   pd_stop_a: assert property (I_PD |=> !osc_run_ff && !ext_run_ff && !valid_ff)
      else $error("Clock activity survived power-down.");

   one_source_a: assert property (!(osc_run_ff && ext_run_ff))
      else $error("Both clock sources enabled together.");

   xo_off_safe_a: assert property ($fell(osc_run_ff) && !$past(I_PD) |-> $past(!gate_ff && !valid_ff))
      else $error("Oscillator turned off with the gate open.");

   gate_low_a: assert property ($changed(gate_ff) |-> $past(!raw_q || missing || I_PD))
      else $error("Gate enable changed during a high phase.");

   refclk_gated_a: assert property (refclk_ff |-> $past(gate_ff && raw_q))
      else $error("Clock passed a closed gate.");

   ready_cause_a: assert property ($rose(valid_ff) |-> $past(raw_rise && end_of_delay) && recal_ff)
      else $error("Ready rose without end of delay or recalibration.");

   amp_drop_a: assert property (amp_lost |=> !valid_ff)
      else $error("Ready held after amplitude loss.");

   bypass_a: assert property (ext_run_ff && !ctrl_ff.amplitude_ok_override && raw_rise && state_ff == SRC_EXT
      && !missing && !I_PD |=> valid_ff)
      else $error("External mode did not bypass the delay.");
endmodule

// ### clock_source_model.sv
// Behavioural crystal resonator and external clock generator at the far side.
`timescale 1ns/1ns

module clock_source_model #(
   parameter int AMP_DELAY = 20
) (
   input  wire logic       i_clk,
   input  wire logic       i_osc_run,
   input  wire logic [3:0] i_hi,
   input  wire logic [3:0] i_lo,
   input  wire logic       i_amp_low,
   output logic            o_osc_raw,
   output logic            o_ext_clk,
   output logic            o_amplitude_ok
);
   int amp_cnt;
   int ph;
   int ext_ph;

   initial begin
      o_osc_raw = 1'b0;
      o_ext_clk = 1'b0;
      o_amplitude_ok = 1'b0;
      amp_cnt = 0;
      ph = 0;
      ext_ph = 0;
   end

   // A stopped core gives no edges, so the raw output rests low.
   always @(posedge i_clk) begin
      if (!i_osc_run) begin
         o_osc_raw <= 1'b0;
         o_amplitude_ok <= 1'b0;
         amp_cnt <= 0;
         ph <= 0;
      end else begin
         if (amp_cnt < AMP_DELAY) begin
            amp_cnt <= amp_cnt + 1;
         end
         // Detection can be held off to mimic a weak resonator that still oscillates.
         o_amplitude_ok <= (amp_cnt >= AMP_DELAY) && !i_amp_low;
         if (ph + 1 >= int'(o_osc_raw ? i_hi : i_lo)) begin
            o_osc_raw <= !o_osc_raw;
            ph <= 0;
         end else begin
            ph <= ph + 1;
         end
      end
   end

   // The external generator is already stable at half duty before it is selected.
   always @(posedge i_clk) begin
      if (ext_ph == 2) begin
         o_ext_clk <= !o_ext_clk;
         ext_ph <= 0;
      end else begin
         ext_ph <= ext_ph + 1;
      end
   end
endmodule

// ### test_ref_clock_source_control.sv
// Self-checking testbench for the reference clock source control block.
`timescale 1ns/1ns
`include "ref_clock_defines.svh"

module test_ref_clock_source_control;
   logic        clk;
   logic        rst;
   logic        pd;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        osc_run;
   logic        ext_run;
   logic        refclk;
   logic        valid;
   logic        observe;
   logic        recal;
   logic        osc_raw;
   logic        ext_clk;
   logic        amp_ok;
   logic        amp_low;
   logic [3:0]  hi_ph;
   logic [3:0]  lo_ph;
   logic [31:0] r;
   int          miscompares;
   int          cmp_count;
   int          recal_n;
   int          ref_rises;
   int          rises;
   int          low_n;
   int          term[4] = '{`DLY_TERM0, `DLY_TERM1, `DLY_TERM2, `DLY_TERM3};

   ref_clock_control dut (.I_CLK(clk), .I_RESET(rst), .I_PD(pd), .I_OSC_RAW(osc_raw),
      .I_EXT_CLK(ext_clk), .I_AMPLITUDE_OK(amp_ok), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_OSC_RUN(osc_run), .O_EXT_BUF_RUN(ext_run),
      .O_REFCLK(refclk), .O_REFCLK_VALID(valid), .O_OBSERVE(observe), .O_PT_RECAL(recal));

   clock_source_model src (.i_clk(clk), .i_osc_run(osc_run), .i_hi(hi_ph), .i_lo(lo_ph),
      .i_amp_low(amp_low), .o_osc_raw(osc_raw), .o_ext_clk(ext_clk), .o_amplitude_ok(amp_ok));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // --------------------------------------------------------------------
   // Comparison and bus tasks
   // --------------------------------------------------------------------
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // The master waits for ready; a slave that never answers is left to the watchdog.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Bounded wait: 0 amplitude good, 1 external buffer running.
   task wait_for(input int which);
      int n;
      n = 0;
      while (n < 300 && (which == 0 ? amp_ok : ext_run) !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) miscompares++;
   endtask

   task count_to_valid(input int limit);
      logic prev;
      int   n;
      rises = 0;
      n = 0;
      prev = ext_run ? ext_clk : osc_raw;
      while (valid !== 1'b1 && n < limit) begin
         @(posedge clk);
         n++;
         if ((ext_run ? ext_clk : osc_raw) && !prev) rises++;
         prev = ext_run ? ext_clk : osc_raw;
      end
      if (valid !== 1'b1) miscompares++;
   endtask

   task restart;
      pd <= 1'b1;
      repeat (5) @(posedge clk);
      cmp_bit(osc_run, 1'b0);
      cmp_bit(ext_run, 1'b0);
      cmp_bit(valid, 1'b0);
      pd <= 1'b0;
      recal_n = 0;
      ref_rises = 0;
   endtask

   always @(posedge clk) begin
      if (recal === 1'b1) recal_n++;
      if (refclk === 1'b1 && valid === 1'b1) ref_rises++;
      low_n <= (valid === 1'b1) ? 0 : low_n + 1;
      // The gate may drain the rest of the raw pulse in progress after ready falls.
      if (low_n > 4) cmp_bit(refclk, 1'b0);
   end

   initial begin
      rst = 1'b1;
      pd = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      amp_low = 1'b0;
      hi_ph = 4'h3;
      lo_ph = 4'h3;
      miscompares = 0;
      cmp_count = 0;
      low_n = 0;
      void'($urandom(32'h4930DC4E));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // Reset values, masking of unused bits and refusal of an unmapped word.
      apb(1'b0, `OFS_CLOCK_CONN, 32'h0);
      cmp_word(rd, 32'h0);
      apb(1'b0, `OFS_EXPERT_CFG, 32'h0);
      cmp_word(rd, 32'h1);
      apb(1'b1, 8'h0C, $urandom);
      cmp_bit(err, 1'b1);
      apb(1'b0, 8'h0C, 32'h0);
      cmp_word(rd, 32'h0);
      r = $urandom;
      apb(1'b1, `OFS_EXPERT_CFG, r);
      apb(1'b0, `OFS_EXPERT_CFG, 32'h0);
      cmp_word(rd, r & 32'h3);
      $display("test registers done");
      for (int sel = 0; sel < 4; sel++) begin
         hi_ph <= 4'($urandom_range(4, 2));
         lo_ph <= 4'($urandom_range(4, 2));
         apb(1'b1, `OFS_EXPERT_CFG, 32'(sel));
         restart();
         wait_for(0);
         count_to_valid(term[sel] * 10 + 200);
         cmp_bit(rises >= term[sel] && rises <= term[sel] + 3, 1'b1);
         repeat (20) @(posedge clk);
         cmp_word(32'(recal_n), 32'h1);
         cmp_bit(ref_rises > 0, 1'b1);
      end
      cmp_bit(observe, amp_ok);
      apb(1'b1, `OFS_CLOCK_CONN, 32'h8);
      repeat (3) @(posedge clk);
      cmp_bit(observe, valid);
      $display("test delay select done");
      apb(1'b1, `OFS_EXPERT_CFG, 32'h0);
      hi_ph <= 4'h1;
      restart();
      wait_for(0);
      repeat (300) @(posedge clk);
      cmp_bit(valid, 1'b0);
      hi_ph <= 4'h3;
      lo_ph <= 4'h1;
      repeat (300) @(posedge clk);
      cmp_bit(valid, 1'b0);
      lo_ph <= 4'h3;
      count_to_valid(400);
      cmp_bit(valid, 1'b1);
      amp_low <= 1'b1;
      repeat (4) @(posedge clk);
      cmp_bit(valid, 1'b0);
      apb(1'b1, `OFS_CLOCK_CONN, 32'h4);
      count_to_valid(400);
      cmp_bit(rises >= 16 && rises <= 19, 1'b1);
      amp_low <= 1'b0;
      $display("test pulse quality done");
      apb(1'b1, `OFS_CLOCK_CONN, 32'h1);
      repeat (60) @(posedge clk);
      cmp_bit(osc_run, 1'b0);
      cmp_bit(ext_run, 1'b0);
      cmp_bit(valid, 1'b0);
      apb(1'b1, `OFS_CLOCK_CONN, 32'h3);
      wait_for(1);
      count_to_valid(200);
      cmp_bit(rises <= 4, 1'b1);
      cmp_bit(osc_run, 1'b0);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp_word(rd, 32'h0000_021A);
      apb(1'b1, `OFS_CLOCK_CONN, 32'h7);
      restart();
      wait_for(1);
      count_to_valid(400);
      cmp_bit(rises >= 16 && rises <= 19, 1'b1);
      apb(1'b1, `OFS_CLOCK_CONN, 32'h2);
      repeat (60) @(posedge clk);
      cmp_bit(osc_run, 1'b1);
      cmp_bit(ext_run, 1'b0);
      $display("test external buffer done");
      give_verdict();
   end

   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule
